// *** switch_link_config_status.sv ***
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Control bit 1 lets a falling pin raise a trap.
// - Control bit 0 pulls the pin low in debug mode.
// - Origin bit 4 marks the pin, bit 0 the tile.
// - Eight external state registers, order C,D,A,B,G,H,E,F.
// - Bits 25:24 give the target link kind.
// - Bits 23:16 give the target link number.
// - Direction in bits 11:8, external links only.
// - Network number in bits 5:4.
// - Bit 2 flags a junk packet.
// - Bit 1 flags outbound routing.
// - Bit 0 flags inbound routing.
// - Four processor link registers without direction.
// - Control bit 31 enables the link and pin muxing.
// - Control bit 30 selects five-wire over two-wire.
// - Sticky error on overflow or bad token, cleared by read.
// - Bit 26 shows credit issued, bit 25 credit held.
// - Bit 24 clears credit and sends a greeting; peer answers.
// - Bit 23 resynchronises the receiver.
// - Bits 21:11 space transitions, bits 10:0 tokens.
module switch_link_config_status
    import link_cfg_pkg::*;
(
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic [link_cfg_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [link_cfg_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic                              debug_pin_n_i,
    output logic                                   debug_pin_n_o,
    output logic                                   debug_pin_n_oe,
    input  wire logic                              node_debug_mode,
    input  wire logic                              tile_debug_event,
    output logic                                   debug_call_trap,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_rx_routed,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_tx_routed,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_junk,
    input  wire logic [2*link_cfg_pkg::N_EXT-1:0]  ext_target_kind,
    input  wire logic [8*link_cfg_pkg::N_EXT-1:0]  ext_target_num,
    input  wire logic [link_cfg_pkg::N_PROC-1:0]   proc_rx_routed,
    input  wire logic [link_cfg_pkg::N_PROC-1:0]   proc_tx_routed,
    input  wire logic [link_cfg_pkg::N_PROC-1:0]   proc_junk,
    input  wire logic [2*link_cfg_pkg::N_PROC-1:0] proc_target_kind,
    input  wire logic [8*link_cfg_pkg::N_PROC-1:0] proc_target_num,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_rx_overflow,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_rx_illegal,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_credit_rx,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_credit_issued,
    input  wire logic [link_cfg_pkg::N_EXT-1:0]    ext_token_sent,
    output logic [link_cfg_pkg::N_EXT-1:0]         ext_enable,
    output logic [link_cfg_pkg::N_EXT-1:0]         ext_wide_mode,
    output logic [link_cfg_pkg::N_EXT-1:0]         ext_tx_allowed,
    output logic [link_cfg_pkg::N_EXT-1:0]         ext_greeting_send,
    output logic [link_cfg_pkg::N_EXT-1:0]         ext_rx_resync,
    output logic [link_cfg_pkg::GAP_W*link_cfg_pkg::N_EXT-1:0] ext_transition_gap,
    output logic [link_cfg_pkg::GAP_W*link_cfg_pkg::N_EXT-1:0] ext_token_gap,
    output logic [link_cfg_pkg::N_EXT-1:0]         dir_unused_o,
    output logic [link_cfg_pkg::N_EXT-1:0]         net_unused_o
);
    import link_cfg_pkg::*;

    // Write and read channel holding state
    logic              aw_have_q;
    logic              w_have_q;
    logic [7:0]        aw_idx_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;

    // Debug state
    logic [1:0]        dbg_ctrl_q;
    logic              org_pin_q;
    logic              org_tile_q;
    logic              pin_prev_q;
    logic              trap_q;
    logic              pull_oe_q;

    // Per-link state
    logic [N_EXT-1:0][3:0]       dir_q;
    logic [N_EXT-1:0][1:0]       ext_net_q;
    logic [N_PROC-1:0][1:0]      proc_net_q;
    logic [N_EXT-1:0]            en_q;
    logic [N_EXT-1:0]            wide_q;
    logic [N_EXT-1:0]            err_q;
    logic [N_EXT-1:0]            issued_q;
    logic [N_EXT-1:0]            held_q;
    logic [N_EXT-1:0]            greet_q;
    logic [N_EXT-1:0]            resync_q;
    logic [N_EXT-1:0][CNT_W-1:0] credit_q;
    logic [N_EXT-1:0][GAP_W-1:0] trgap_q;
    logic [N_EXT-1:0][GAP_W-1:0] tokgap_q;

    // Write decode: fires once both address and data are held
    wire        wr_fire   = aw_have_q & w_have_q & ~bvalid_q;
    wire [31:0] wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                             {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] wbits     = wdata_q & wmask;
    wire        wr_dbg    = wr_fire & (aw_idx_q == IDX_DBG_CTRL);
    wire        wr_org    = wr_fire & (aw_idx_q == IDX_DBG_ORIGIN);
    wire        wr_ext_st = wr_fire & (aw_idx_q[7:3] == IDX_EXT_STATE[7:3]);
    wire        wr_proc   = wr_fire & (aw_idx_q[7:2] == IDX_PROC_STATE[7:2]);
    wire        wr_ctrl   = wr_fire & (aw_idx_q[7:3] == IDX_EXT_CTRL[7:3]);
    wire        wr_hit    = (aw_idx_q == IDX_DBG_CTRL) | (aw_idx_q == IDX_DBG_ORIGIN)
                          | (aw_idx_q[7:3] == IDX_EXT_STATE[7:3])
                          | (aw_idx_q[7:2] == IDX_PROC_STATE[7:2])
                          | (aw_idx_q[7:3] == IDX_EXT_CTRL[7:3]);

    // Read decode
    wire [7:0]  ar_idx    = s_axi_araddr[9:2];
    wire        rd_fire   = s_axi_arvalid & ~rvalid_q;
    wire        rd_ext_st = ar_idx[7:3] == IDX_EXT_STATE[7:3];
    wire        rd_proc   = ar_idx[7:2] == IDX_PROC_STATE[7:2];
    wire        rd_ctrl   = ar_idx[7:3] == IDX_EXT_CTRL[7:3];
    wire        rd_hit    = (ar_idx == IDX_DBG_CTRL) | (ar_idx == IDX_DBG_ORIGIN)
                          | rd_ext_st | rd_proc | rd_ctrl;
    wire [2:0]  rd_e      = ar_idx[2:0];
    wire [1:0]  rd_p      = ar_idx[1:0];

    // Debug pin falling edge, pin taken as synchronous already
    wire        pin_fall  = pin_prev_q & ~debug_pin_n_i;
    wire        pin_event = pin_fall & dbg_ctrl_q[DBG_TRAP_BIT];

    // Read data images per register
    logic [N_EXT-1:0][31:0]  ext_st_img;
    logic [N_PROC-1:0][31:0] proc_st_img;
    logic [N_EXT-1:0][31:0]  ctrl_img;
    logic [31:0]             rd_mux;

    assign s_axi_awready = ~aw_have_q & ~bvalid_q;
    assign s_axi_wready  = ~w_have_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // AXI write handshake; address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_idx_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // AXI read; data captured at the address edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_DECERR;
            rdata_q  <= rd_hit ? rd_mux : 32'h0000_0000;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Read selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ar_idx == IDX_DBG_CTRL) begin
            rd_mux[1:0] = dbg_ctrl_q;
        end else if (ar_idx == IDX_DBG_ORIGIN) begin
            rd_mux[ORG_PIN_BIT]  = org_pin_q;
            rd_mux[ORG_TILE_BIT] = org_tile_q;
        end else if (rd_ext_st) begin
            rd_mux = ext_st_img[rd_e];
        end else if (rd_proc) begin
            rd_mux = proc_st_img[rd_p];
        end else if (rd_ctrl) begin
            rd_mux = ctrl_img[rd_e];
        end
    end

    // Debug pin control, trap and origin tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbg_ctrl_q <= 2'h0;
            org_pin_q  <= 1'b0;
            org_tile_q <= 1'b0;
            pin_prev_q <= 1'b1;
            trap_q     <= 1'b0;
            pull_oe_q  <= 1'b0;
        end else begin
            pin_prev_q <= debug_pin_n_i;
            if (wr_dbg) begin
                dbg_ctrl_q <= wbits[1:0];
            end
            trap_q    <= pin_event;
            pull_oe_q <= dbg_ctrl_q[DBG_PULL_BIT] & node_debug_mode;
            // Hardware events win over a software write in the same cycle
            if (pin_event || tile_debug_event) begin
                org_pin_q  <= pin_event;
                org_tile_q <= tile_debug_event & ~pin_event;
            end else if (wr_org) begin
                org_pin_q  <= wbits[ORG_PIN_BIT];
                org_tile_q <= wbits[ORG_TILE_BIT];
            end
        end
    end

    assign debug_call_trap = trap_q;
    assign debug_pin_n_oe  = pull_oe_q;
    assign debug_pin_n_o   = 1'b0; // Only ever pulls low, open-drain style

    // External links: route state image and control registers
    genvar gi;
    generate
        for (gi = 0; gi < N_EXT; gi++) begin : g_ext
            wire sel      = aw_idx_q[2:0] == 3'(gi);
            wire st_wr    = wr_ext_st & sel;
            wire ct_wr    = wr_ctrl & sel;
            wire ct_rd    = rd_fire & rd_ctrl & (rd_e == 3'(gi));
            wire init     = ct_wr & wbits[INIT_BIT];
            wire err_set  = ext_rx_overflow[gi] | ext_rx_illegal[gi];
            wire can_send = credit_q[gi] != {CNT_W{1'b0}};
            logic [CNT_W-1:0] credit_d;

            always_comb begin
                credit_d = credit_q[gi];
                if (init) begin
                    credit_d = {CNT_W{1'b0}};
                end else begin
                    if (ext_credit_rx[gi] && credit_q[gi] != {CNT_W{1'b1}}) begin
                        credit_d = credit_d + 1'b1;
                    end
                    if (ext_token_sent[gi] && can_send) begin
                        credit_d = credit_d - 1'b1;
                    end
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    dir_q[gi]     <= DIR_RST;
                    ext_net_q[gi] <= NET_RST;
                    en_q[gi]      <= 1'b0;
                    wide_q[gi]    <= 1'b0;
                    trgap_q[gi]   <= GAP_RST;
                    tokgap_q[gi]  <= GAP_RST;
                    err_q[gi]     <= 1'b0;
                    issued_q[gi]  <= 1'b0;
                    held_q[gi]    <= 1'b0;
                    greet_q[gi]   <= 1'b0;
                    resync_q[gi]  <= 1'b0;
                    credit_q[gi]  <= {CNT_W{1'b0}};
                end else begin
                    if (st_wr) begin
                        dir_q[gi]     <= wbits[DIR_LSB +: 4];
                        ext_net_q[gi] <= wbits[NET_LSB +: 2];
                    end
                    if (ct_wr) begin
                        en_q[gi]     <= wbits[EN_BIT];
                        wide_q[gi]   <= wbits[WIDE_BIT];
                        trgap_q[gi]  <= wbits[TRGAP_LSB +: GAP_W];
                        tokgap_q[gi] <= wbits[TOKGAP_LSB +: GAP_W];
                    end
                    // Set beats the clear-on-read in the same cycle
                    if (err_set) begin
                        err_q[gi] <= 1'b1;
                    end else if (ct_rd) begin
                        err_q[gi] <= 1'b0;
                    end
                    if (ext_credit_issued[gi]) begin
                        issued_q[gi] <= 1'b1;
                    end else if (init || !en_q[gi]) begin
                        issued_q[gi] <= 1'b0;
                    end
                    credit_q[gi] <= credit_d;
                    held_q[gi]   <= credit_d != {CNT_W{1'b0}};
                    greet_q[gi]  <= init;
                    resync_q[gi] <= ct_wr & wbits[RXRST_BIT];
                end
            end

            always_comb begin
                ext_st_img[gi] = 32'h0000_0000;
                ext_st_img[gi][KIND_LSB +: 2]   = ext_target_kind[2*gi +: 2];
                ext_st_img[gi][TARGET_LSB +: 8] = ext_target_num[8*gi +: 8];
                ext_st_img[gi][DIR_LSB +: 4]    = dir_q[gi];
                ext_st_img[gi][NET_LSB +: 2]    = ext_net_q[gi];
                ext_st_img[gi][JUNK_BIT]        = ext_junk[gi];
                ext_st_img[gi][TX_ROUTE_BIT]    = ext_tx_routed[gi];
                ext_st_img[gi][RX_ROUTE_BIT]    = ext_rx_routed[gi];
            end

            // Write-only pulse bits read back as zero
            always_comb begin
                ctrl_img[gi] = 32'h0000_0000;
                ctrl_img[gi][EN_BIT]               = en_q[gi];
                ctrl_img[gi][WIDE_BIT]             = wide_q[gi];
                ctrl_img[gi][ERR_BIT]              = err_q[gi];
                ctrl_img[gi][ISSUED_BIT]           = issued_q[gi];
                ctrl_img[gi][HELD_BIT]             = held_q[gi];
                ctrl_img[gi][TRGAP_LSB +: GAP_W]   = trgap_q[gi];
                ctrl_img[gi][TOKGAP_LSB +: GAP_W]  = tokgap_q[gi];
            end

            assign ext_transition_gap[GAP_W*gi +: GAP_W] = trgap_q[gi];
            assign ext_token_gap[GAP_W*gi +: GAP_W]      = tokgap_q[gi];
        end
    endgenerate

    // Processor links: network number only, no direction field
    generate
        for (gi = 0; gi < N_PROC; gi++) begin : g_proc
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    proc_net_q[gi] <= NET_RST;
                end else if (wr_proc && aw_idx_q[1:0] == 2'(gi)) begin
                    proc_net_q[gi] <= wbits[NET_LSB +: 2];
                end
            end

            always_comb begin
                proc_st_img[gi] = 32'h0000_0000;
                proc_st_img[gi][KIND_LSB +: 2]   = proc_target_kind[2*gi +: 2];
                proc_st_img[gi][TARGET_LSB +: 8] = proc_target_num[8*gi +: 8];
                proc_st_img[gi][NET_LSB +: 2]    = proc_net_q[gi];
                proc_st_img[gi][JUNK_BIT]        = proc_junk[gi];
                proc_st_img[gi][TX_ROUTE_BIT]    = proc_tx_routed[gi];
                proc_st_img[gi][RX_ROUTE_BIT]    = proc_rx_routed[gi];
            end
        end
    endgenerate

    // Link control outputs straight from their flops
    assign ext_enable        = en_q;
    assign ext_wide_mode     = wide_q;
    assign ext_tx_allowed    = held_q;
    assign ext_greeting_send = greet_q;
    assign ext_rx_resync     = resync_q;

    // Direction and network are for the router outside; nonzero flags ease probing
    generate
        for (gi = 0; gi < N_EXT; gi++) begin : g_flag
            logic dflag_q;
            logic nflag_q;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    dflag_q <= 1'b0;
                    nflag_q <= 1'b0;
                end else begin
                    dflag_q <= dir_q[gi] != DIR_RST;
                    nflag_q <= ext_net_q[gi] != NET_RST;
                end
            end
            assign dir_unused_o[gi] = dflag_q;
            assign net_unused_o[gi] = nflag_q;
        end
    endgenerate

endmodule // switch_link_config_status

// *** link_cfg_pkg.sv ***
package link_cfg_pkg;
    // Bus geometry; register byte address is four times the index
    localparam int ADDR_W = 10;
    localparam int N_EXT  = 8;
    localparam int N_PROC = 4;
    localparam int GAP_W  = 11;
    localparam int CNT_W  = 8;

    // Register indices
    localparam logic [7:0] IDX_DBG_CTRL   = 8'h10;
    localparam logic [7:0] IDX_DBG_ORIGIN = 8'h1F;
    localparam logic [7:0] IDX_EXT_STATE  = 8'h20;
    localparam logic [7:0] IDX_PROC_STATE = 8'h40;
    localparam logic [7:0] IDX_EXT_CTRL   = 8'h80;

    // Debug pin control and origin fields
    localparam int DBG_PULL_BIT = 0;
    localparam int DBG_TRAP_BIT = 1;
    localparam int ORG_TILE_BIT = 0;
    localparam int ORG_PIN_BIT  = 4;

    // Route state fields
    localparam int RX_ROUTE_BIT = 0;
    localparam int TX_ROUTE_BIT = 1;
    localparam int JUNK_BIT     = 2;
    localparam int NET_LSB      = 4;
    localparam int DIR_LSB      = 8;
    localparam int TARGET_LSB   = 16;
    localparam int KIND_LSB     = 24;

    // Link control fields
    localparam int TOKGAP_LSB = 0;
    localparam int TRGAP_LSB  = 11;
    localparam int RXRST_BIT  = 23;
    localparam int INIT_BIT   = 24;
    localparam int HELD_BIT   = 25;
    localparam int ISSUED_BIT = 26;
    localparam int ERR_BIT    = 27;
    localparam int WIDE_BIT   = 30;
    localparam int EN_BIT     = 31;

    // Reset values
    localparam logic [3:0]       DIR_RST = 4'h0;
    localparam logic [1:0]       NET_RST = 2'h0;
    localparam logic [GAP_W-1:0] GAP_RST = 11'h000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** switch_link_config_status_checker.sv ***
`timescale 1ns/1ps
module switch_link_config_status_checker
    import link_cfg_pkg::*;
(
    input wire logic aclk, aresetn, debug_pin_n_i, debug_pin_n_o, debug_pin_n_oe,
    input wire logic node_debug_mode, debug_call_trap, s_axi_bvalid, s_axi_rvalid,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_arvalid, s_axi_arready,
    input wire logic [link_cfg_pkg::N_EXT-1:0] ext_greeting_send, ext_rx_resync,
    input wire logic [link_cfg_pkg::N_EXT-1:0] ext_tx_allowed, ext_credit_rx,
    input wire logic [link_cfg_pkg::N_EXT-1:0] ext_enable, ext_wide_mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Debug pin side: trap and pull-down follow their causes
    property p_trap; debug_call_trap |-> $past(!debug_pin_n_i) ##1 !debug_call_trap; endproperty
    a_trap: assert property (p_trap) else $error("trap without low pin");
    property p_pull; debug_pin_n_oe |-> !debug_pin_n_o && $past(node_debug_mode); endproperty
    a_pull: assert property (p_pull) else $error("pin pulled outside debug");
    // Self-clearing strobes last one cycle
    property p_greet; ext_greeting_send != 8'h00 |=> ext_greeting_send == 8'h00; endproperty
    a_greet: assert property (p_greet) else $error("greeting too long");
    property p_resync; ext_rx_resync != 8'h00 |=> ext_rx_resync == 8'h00; endproperty
    a_resync: assert property (p_resync) else $error("resync too long");
    // Credit only appears after a credit arrives, never beside a greeting
    property p_cred; !(|(ext_tx_allowed & ~$past(ext_tx_allowed) & ~$past(ext_credit_rx)));
    endproperty
    a_cred: assert property (p_cred) else $error("credit from nowhere");
    property p_gclr; (ext_greeting_send & ext_tx_allowed) == 8'h00; endproperty
    a_gclr: assert property (p_gclr) else $error("credit kept over init");
    // Bus answers and config changes only through a write
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write not answered");
    property p_cfg; $changed({ext_enable, ext_wide_mode}) |-> s_axi_bvalid; endproperty
    a_cfg: assert property (p_cfg) else $error("config moved without write");
endmodule // switch_link_config_status_checker
bind switch_link_config_status switch_link_config_status_checker
    switch_link_config_status_checker_i (.*);

// *** link_peer_model.sv ***
`timescale 1ns/1ps
module link_peer_model #(parameter int DLY = 3, parameter int NCRED = 2) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] greeting,
    output logic      [7:0] credit
);
    logic [7:0] pend_q, wait_q, left_q;
    // Far node answers a greeting with a short credit burst, late on purpose
    always_ff @(posedge aclk) begin
        credit <= 8'h00;
        if (!aresetn) begin
            {pend_q, wait_q, left_q} <= '0;
        end else if (greeting != 8'h00) begin
            {pend_q, wait_q, left_q} <= {greeting, 8'(DLY), 8'(NCRED)};
        end else if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end else if (left_q != 8'h00) begin
            credit <= pend_q;
            left_q <= left_q - 8'h01;
        end
    end
endmodule // link_peer_model

// *** switch_link_config_status_test.sv ***
`timescale 1ns/1ps
module switch_link_config_status_test;
    import link_cfg_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic debug_pin_n_i, debug_pin_n_o, debug_pin_n_oe, node_debug_mode, tile_debug_event;
    logic debug_call_trap;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, proc_target_num, d;
    logic [3:0] s_axi_wstrb, proc_rx_routed, proc_tx_routed, proc_junk;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] ext_rx_routed, ext_tx_routed, ext_junk, ext_rx_overflow, ext_rx_illegal;
    logic [7:0] ext_credit_rx, ext_credit_issued, ext_token_sent, ext_enable, ext_wide_mode;
    logic [7:0] ext_tx_allowed, ext_greeting_send, ext_rx_resync, dir_unused_o, net_unused_o;
    logic [7:0] proc_target_kind;
    logic [15:0] ext_target_kind;
    logic [63:0] ext_target_num;
    logic [87:0] ext_transition_gap, ext_token_gap;
    int n_mismatch = 0;
    int checked = 0;
    int n;
    logic [9:0] ta [6] = '{10'h040, 10'h07C, 10'h09C, 10'h10C, 10'h21C, 10'h3FC};
    logic [31:0] te [6] = '{32'h3, 32'h11, 32'h02A50F37, 32'h013C0037, 32'hC03FFFFF, 32'h0};
    switch_link_config_status switch_link_config_status_i (.*);
    link_peer_model #(.DLY(3), .NCRED(2)) link_peer_model_i (.aclk(aclk), .aresetn(aresetn),
        .greeting(ext_greeting_send), .credit(ext_credit_rx));
    // Clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Every wait is bounded; running out ends the run
    task automatic guard();
        if (n >= 40) begin
            chk("timeout", 32'h1, 32'h0);
            test_done();
        end
    endtask
    // Bus master: bready and rready stay high, so each answer is taken at once
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'b11};
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        guard();
    endtask
    task automatic rd(input logic [9:0] a);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        guard();
    endtask
    task automatic rc(input logic [9:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), d, e);
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, node_debug_mode, tile_debug_event} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_rx_overflow, ext_rx_illegal} = '0;
        {ext_credit_issued, ext_token_sent, aresetn} = '0;
        {s_axi_bready, s_axi_rready, debug_pin_n_i, s_axi_wstrb} = '1;
        {ext_rx_routed, ext_tx_routed, ext_junk, proc_rx_routed, proc_tx_routed} = 32'h80808088;
        {proc_junk, proc_target_kind, proc_target_num} = {4'h8, 8'h40, 8'h3C, 24'h0};
        {ext_target_kind, ext_target_num} = {16'h8000, 8'hA5, 56'h0};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(10'h040, 32'h0);
        rc(10'h200, 32'h0);
        rc(10'h09C, 32'h02A50007);
        for (int i = 0; i < 6; i++) begin
            wr(ta[i], i == 4 ? 32'hC07FFFFF : 32'hFFFFFFFF);
            rc(ta[i], te[i]);
            chk("resp", {30'h0, r}, i == 5 ? 32'h3 : 32'h0);
        end
        chk("flags", {16'h0, dir_unused_o, net_unused_o}, 32'h8080);
        $display("test table done");
        // Init, peer credits, then two tokens drain them
        wr(10'h200, 32'h81000000);
        chk("greet", {24'h0, ext_greeting_send}, 32'h1);
        for (n = 0; n < 40 && ext_tx_allowed[0] !== 1'b1; n++) @(posedge aclk);
        guard();
        rc(10'h200, 32'h82000000);
        ext_token_sent <= 8'h01;
        repeat (2) @(posedge aclk);
        ext_token_sent <= 8'h00;
        @(posedge aclk);
        #1 chk("tx allowed", {24'h0, ext_tx_allowed}, 32'h0);
        @(posedge aclk);
        for (int j = 0; j < 2; j++) begin
            {ext_rx_overflow, ext_rx_illegal} <= j == 0 ? 16'h0200 : 16'h0002;
            @(posedge aclk);
            {ext_rx_overflow, ext_rx_illegal} <= 16'h0;
            @(posedge aclk);
            rc(10'h204, 32'h08000000);
            rc(10'h204, 32'h0);
        end
        wr(10'h204, 32'h00800000);
        chk("resync", {24'h0, ext_rx_resync}, 32'h2);
        @(posedge aclk);
        rc(10'h204, 32'h0);
        wr(10'h208, 32'h80000000);
        ext_credit_issued <= 8'h04;
        @(posedge aclk);
        ext_credit_issued <= 8'h00;
        rc(10'h208, 32'h84000000);
        chk("modes", {ext_enable, ext_wide_mode}, 32'h8580);
        chk("gaps", {ext_transition_gap[87:77], ext_token_gap[87:77]}, 32'h3FFFFF);
        $display("test link done");
        // Debug pin: pull-down, trap, origin from pin then from tile
        node_debug_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("pull", {debug_pin_n_oe, debug_pin_n_o}, 32'h2);
        debug_pin_n_i <= 1'b0;
        for (n = 0; n < 40 && debug_call_trap !== 1'b1; n++) @(posedge aclk);
        guard();
        @(posedge aclk);
        rc(10'h07C, 32'h10);
        {debug_pin_n_i, node_debug_mode, tile_debug_event} <= 3'b101;
        @(posedge aclk);
        tile_debug_event <= 1'b0;
        rc(10'h07C, 32'h01);
        $display("test debug done");
        test_done();
    end
endmodule // switch_link_config_status_test
